// File: inc/spisl_pkg.sv
// Constants for the serial port block: field positions, reset values, timing.
// Assumes a CPU-side clock of 25 MHz and an external link clock on its own port.
package spisl_pkg;
   localparam int SPISL_BITS = 8;
   localparam logic [2:0] SPISL_CNT_LAST = 3'h7;
   localparam logic [7:0] SPISL_BYTE_RST = 8'h00;
   // Control bit positions
   localparam int SPISL_CR_RATE0 = 0;
   localparam int SPISL_CR_RATE1 = 1;
   localparam int SPISL_CR_PHASE = 2;
   localparam int SPISL_CR_IDLE = 3;
   localparam int SPISL_CR_MASTER_SELECT_BIT = 4;
   localparam int SPISL_CR_RATE2 = 5;
   localparam int SPISL_CR_PINS = 6;
   localparam int SPISL_CR_IRQEN = 7;
   localparam logic [7:0] SPISL_CR_RST = 8'h00;
   // Status bit positions
   localparam int SPISL_SR_DONE = 7;
   localparam int SPISL_SR_CLASH = 6;
   localparam int SPISL_SR_FAULT = 4;
   // Master-mode serial clock half period in CPU cycles
   localparam int SPISL_CLK_NS = 40;
   localparam int SPISL_HALF_NS = 80;
   localparam int SPISL_HALF_CYC = (SPISL_HALF_NS + SPISL_CLK_NS - 1) / SPISL_CLK_NS;
   typedef enum logic [1:0] {
      SPISL_M_IDLE = 2'b00,
      SPISL_M_LEAD = 2'b01,
      SPISL_M_TRAIL = 2'b11
   } spisl_mst_t;
endpackage : spisl_pkg

// File: core/spisl_core.sv
// Byte-wide synchronous serial port, slave and master, with collision and fault flags.
// Assumes the CPU strobes are one-cycle pulses on clock; the slave clock arrives on
// link_sck with its own domain, and the select pin is asynchronous.
// What this block does
// - Done flag clears after status access with flag set, then data read.
// - While done flag set, data writes are ignored until status is accessed.
// - Slave takes clock from pin, ignores rate bits, mosi in, miso out.
// - Data write loads the 8-bit shifter; sent most significant bit first.
// - Last cycle sets done flag and copies received byte to the read buffer.
// - Interrupt on completion only when enabled and CPU mask clear.
// - Each transfer shifts in and out together over exactly eight clock pulses.
// - Idle level bit sets resting level of serial clock in both modes.
// - Phase set: most significant bit captured on the second clock edge.
// - Phase clear: most significant bit captured on the first clock edge.
// - Phase clear: low select freezes data register; master toggles select per byte.
// - Phase set: first clock edge drives msb; second clock edge freezes data; select alone does not.
// - Slave, phase clear: data write after select low is a collision.
// - Master: data write during internal transfer is a collision; keep select high.
// - Collision discards write, transfer continues unchanged, clash flag set.
// - Clash flag is status only and never requests an interrupt.
// - Select low in master mode sets fault, clears pin enable and master bit.
// - Fault clears by status access with flag set, then control write.
// - Fault set blocks setting pin and master bits except in clearing write.
// - Bytes arriving while done flag set are lost; buffer keeps first byte.
// - Master starts a byte only on a data register write.
module spisl_core (
   input wire logic clock,
   input wire logic sys_rst,
   input wire logic clk_en,
   input wire logic link_sck,
   input wire logic link_mosi_in,
   input wire logic link_miso_in,
   input wire logic link_sel_n,
   output logic sck_out,
   output logic sck_oe,
   output logic mosi_out,
   output logic mosi_oe,
   output logic miso_out,
   output logic miso_oe,
   input wire logic [7:0] ctrl_wdata,
   input wire logic ctrl_wr,
   output logic [7:0] ctrl_rdata,
   input wire logic status_rd,
   input wire logic status_wr,
   output logic [7:0] status_rdata,
   input wire logic [7:0] data_wdata,
   input wire logic data_wr,
   input wire logic data_rd,
   output logic [7:0] data_rdata,
   input wire logic cpu_irq_mask,
   output logic irq_req
);
   import spisl_pkg::*;

   logic [7:0] ctrl_reg;
   logic done_reg, clash_reg, fault_reg;
   logic done_seen_reg, clash_seen_reg, fault_seen_reg;
   logic [7:0] buf_reg;
   logic [7:0] tx_reg;
   logic tx_tog_reg;
   logic [1:0] sel_sync_reg;
   logic [1:0] done_sync_reg;
   logic done_ack_reg;
   logic first_reg;
   logic [1:0] act_sync_reg;

   // Link-domain state
   logic [7:0] lk_shift_reg;
   logic [7:0] lk_rx_reg;
   logic [2:0] lk_cnt_reg;
   logic lk_full_reg;
   logic lk_busy_reg;
   logic lk_lead_reg;

   // Master-domain state
   spisl_mst_t mst_state;
   logic [7:0] m_shift_reg;
   logic [2:0] m_cnt_reg;
   logic [7:0] m_div_reg;
   logic m_sck_reg;
   logic m_in_reg;

   wire is_master = ctrl_reg[SPISL_CR_MASTER_SELECT_BIT];
   wire pins_on = ctrl_reg[SPISL_CR_PINS];
   wire clock_idle_level = ctrl_reg[SPISL_CR_IDLE];
   wire capture_phase_bit = ctrl_reg[SPISL_CR_PHASE];
   wire sel_low = ~sel_sync_reg[1];
   wire slave_done_ev = done_sync_reg[1] & ~done_ack_reg;
   wire slave_act = act_sync_reg[1];
   wire m_busy = (mst_state != SPISL_M_IDLE);
   wire m_done_ev = (mst_state == SPISL_M_TRAIL) && (m_cnt_reg == SPISL_CNT_LAST)
      && (m_div_reg == 8'(SPISL_HALF_CYC - 1));
   wire xfer_done = is_master ? m_done_ev : slave_done_ev;
   // Phase set captures the last bit on the completing edge itself
   wire m_in_now = capture_phase_bit ? link_miso_in : m_in_reg;

   // Select pin passes two flip-flops before use
   always_ff @(posedge clock) begin
      if (sys_rst) sel_sync_reg <= 2'b11;
      else if (clk_en) sel_sync_reg <= {sel_sync_reg[0], link_sel_n};
   end

   // Write collision decode, shared by data path and flag
   function automatic logic clash_of(input logic mst, input logic ph, input logic sl,
                                     input logic mb, input logic sact);
      if (mst) clash_of = mb;
      else if (!ph) clash_of = sl;
      else clash_of = sact;
   endfunction : clash_of

   wire wr_clash = clash_of(is_master, capture_phase_bit, sel_low, m_busy, slave_act);
   wire wr_block = done_reg && !done_seen_reg;
   wire wr_ok = data_wr && !wr_block && !wr_clash;

   // Control register with master fault handling
   always_ff @(posedge clock) begin
      if (sys_rst) ctrl_reg <= SPISL_CR_RST;
      else if (clk_en) begin
         if (is_master && sel_low) begin
            ctrl_reg[SPISL_CR_PINS] <= 1'b0;
            ctrl_reg[SPISL_CR_MASTER_SELECT_BIT] <= 1'b0;
         end else if (ctrl_wr) begin
            ctrl_reg <= ctrl_wdata;
            if (fault_reg && !fault_seen_reg) begin
               // Fault pending outside the clearing sequence: keep bits from rising
               ctrl_reg[SPISL_CR_PINS] <= ctrl_wdata[SPISL_CR_PINS] & pins_on;
               ctrl_reg[SPISL_CR_MASTER_SELECT_BIT] <= ctrl_wdata[SPISL_CR_MASTER_SELECT_BIT] & is_master;
            end
         end
      end
   end

   // Done flag: set wins over the clearing read
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         done_reg <= 1'b0;
         done_seen_reg <= 1'b0;
      end else if (clk_en) begin
         if (xfer_done) begin
            done_reg <= 1'b1;
            done_seen_reg <= 1'b0;
         end else if (done_seen_reg && data_rd) begin
            done_reg <= 1'b0;
            done_seen_reg <= 1'b0;
         end else if (done_reg && (status_rd || status_wr)) done_seen_reg <= 1'b1;
      end
   end

   // Clash flag
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         clash_reg <= 1'b0;
         clash_seen_reg <= 1'b0;
      end else if (clk_en) begin
         if (data_wr && !wr_block && wr_clash) clash_reg <= 1'b1;
         else if (clash_seen_reg && (data_rd || data_wr)) begin
            clash_reg <= 1'b0;
            clash_seen_reg <= 1'b0;
         end else if (clash_reg && status_rd) clash_seen_reg <= 1'b1;
      end
   end

   // Mode fault flag, only possible in master mode
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         fault_reg <= 1'b0;
         fault_seen_reg <= 1'b0;
      end else if (clk_en) begin
         if (is_master && sel_low) begin
            fault_reg <= 1'b1;
            fault_seen_reg <= 1'b0;
         end else if (fault_seen_reg && ctrl_wr) begin
            fault_reg <= 1'b0;
            fault_seen_reg <= 1'b0;
         end else if (fault_reg && (status_rd || status_wr)) fault_seen_reg <= 1'b1;
      end
   end

   // Read buffer keeps the first byte after a clear
   always_ff @(posedge clock) begin
      if (sys_rst) buf_reg <= SPISL_BYTE_RST;
      else if (clk_en && xfer_done && !done_reg) begin
         buf_reg <= is_master ? {m_shift_reg[6:0], m_in_now} : lk_rx_reg;
      end
   end

   // Transmit byte, handed to the link by toggle; held stable while link is active
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         tx_reg <= SPISL_BYTE_RST;
         tx_tog_reg <= 1'b0;
      end else if (clk_en && wr_ok) begin
         tx_reg <= data_wdata;
         tx_tog_reg <= ~tx_tog_reg;
      end
   end

   // Crossing back: byte-full level, received byte, active level. The full level rises
   // on the last link edge; the edge detector resets high so a standing level is no event.
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         done_sync_reg <= 2'b11;
         done_ack_reg <= 1'b1;
         act_sync_reg <= 2'b00;
      end else if (clk_en) begin
         done_sync_reg <= {done_sync_reg[0], lk_full_reg};
         act_sync_reg <= {act_sync_reg[0], lk_busy_reg};
         done_ack_reg <= done_sync_reg[1];
      end
   end

   // Link domain: slave shifter on the external clock, polarity folded in
   wire lk_clk = link_sck ^ clock_idle_level ^ capture_phase_bit;
   // The write side is frozen while a frame runs (collision rules), so the link reads the
   // byte and its toggle directly: its clock only runs inside frames, so it cannot sync.
   // Limitation: the first link edge must come at least a few CPU cycles after select falls.
   wire new_byte = (lk_cnt_reg == 3'h0) && (tx_tog_reg != first_reg);
   wire [7:0] lk_load = new_byte ? tx_reg : lk_shift_reg;

   always_ff @(posedge lk_clk or posedge link_sel_n) begin
      if (link_sel_n) begin
         lk_cnt_reg <= 3'h0;
         lk_busy_reg <= 1'b0;
      end else begin
         lk_busy_reg <= 1'b1;
         lk_cnt_reg <= lk_cnt_reg + 3'h1;
      end
   end

   // Phase set: the first, non-capturing edge starts driving the msb
   always_ff @(negedge lk_clk or posedge link_sel_n) begin
      if (link_sel_n) lk_lead_reg <= 1'b0;
      else lk_lead_reg <= 1'b1;
   end

   // Edges seen while deselected come from polarity changes and are ignored
   always_ff @(posedge lk_clk) begin
      if (!link_sel_n) begin
         lk_shift_reg <= {lk_load[6:0], link_mosi_in};
         if (lk_cnt_reg == SPISL_CNT_LAST) begin
            lk_rx_reg <= {lk_shift_reg[6:0], link_mosi_in};
            lk_full_reg <= 1'b1;
         end else if (lk_cnt_reg == 3'h0) lk_full_reg <= 1'b0;
      end
   end

   // Mark consumption of a written byte in the link domain
   always_ff @(posedge lk_clk) begin
      if (!link_sel_n && lk_cnt_reg == 3'h0) first_reg <= tx_tog_reg;
   end

   // Unused rate bits in slave mode; the pin enable gates all pin drive
   assign miso_out = lk_busy_reg ? lk_shift_reg[7] : lk_load[7];
   assign miso_oe = pins_on && !is_master && !link_sel_n && (lk_lead_reg || capture_phase_bit == 1'b0);

   // Master engine, started only by a data write
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         mst_state <= SPISL_M_IDLE;
         m_shift_reg <= SPISL_BYTE_RST;
         m_cnt_reg <= 3'h0;
         m_div_reg <= 8'h00;
         m_sck_reg <= 1'b0;
         m_in_reg <= 1'b0;
      end else if (clk_en) begin
         case (mst_state)
            SPISL_M_IDLE: begin
               m_sck_reg <= clock_idle_level;
               if (is_master && wr_ok) begin
                  m_shift_reg <= data_wdata;
                  m_cnt_reg <= 3'h0;
                  m_div_reg <= 8'h00;
                  mst_state <= SPISL_M_LEAD;
               end
            end
            SPISL_M_LEAD: begin
               if (m_div_reg == 8'(SPISL_HALF_CYC - 1)) begin
                  m_div_reg <= 8'h00;
                  m_sck_reg <= ~m_sck_reg;
                  // Phase set keeps the msb on the line through its first capture
                  if (!capture_phase_bit) m_in_reg <= link_miso_in;
                  else if (m_cnt_reg != 3'h0) m_shift_reg <= {m_shift_reg[6:0], m_in_reg};
                  mst_state <= SPISL_M_TRAIL;
               end else m_div_reg <= m_div_reg + 8'h01;
            end
            SPISL_M_TRAIL: begin
               if (m_div_reg == 8'(SPISL_HALF_CYC - 1)) begin
                  m_div_reg <= 8'h00;
                  m_sck_reg <= ~m_sck_reg;
                  if (capture_phase_bit) m_in_reg <= link_miso_in;
                  else m_shift_reg <= {m_shift_reg[6:0], m_in_reg};
                  m_cnt_reg <= m_cnt_reg + 3'h1;
                  mst_state <= (m_cnt_reg == SPISL_CNT_LAST) ? SPISL_M_IDLE : SPISL_M_LEAD;
               end else m_div_reg <= m_div_reg + 8'h01;
            end
            default: mst_state <= SPISL_M_IDLE;
         endcase
         if (!is_master) mst_state <= SPISL_M_IDLE;
      end
   end

   assign sck_out = m_busy ? m_sck_reg : clock_idle_level;
   assign sck_oe = pins_on && is_master;
   assign mosi_out = m_shift_reg[7];
   assign mosi_oe = pins_on && is_master;

   // Interrupt: completion or fault, gated by enable and CPU mask; clash never counts
   assign irq_req = ctrl_reg[SPISL_CR_IRQEN] && !cpu_irq_mask
      && (done_reg || fault_reg);

   assign ctrl_rdata = ctrl_reg;
   assign status_rdata = {done_reg, clash_reg, 1'b0, fault_reg, 4'h0};
   assign data_rdata = buf_reg;

   a_irq_gate: assert property (@(posedge clock) disable iff (sys_rst)
      irq_req |-> (ctrl_reg[SPISL_CR_IRQEN] && !cpu_irq_mask))
      else $error("interrupt without enable");
   a_clash_noirq: assert property (@(posedge clock) disable iff (sys_rst)
      (clash_reg && !done_reg && !fault_reg) |-> !irq_req)
      else $error("clash raised interrupt");
   a_fault_force: assert property (@(posedge clock) disable iff (sys_rst)
      (clk_en && is_master && sel_low) |=> (fault_reg && !is_master && !pins_on))
      else $error("fault did not force slave");
   a_done_block: assert property (@(posedge clock) disable iff (sys_rst)
      (clk_en && data_wr && done_reg && !done_seen_reg) |=> $stable(tx_reg))
      else $error("write while done accepted");
   a_clash_keep: assert property (@(posedge clock) disable iff (sys_rst)
      (clk_en && data_wr && !wr_block && wr_clash) |=> (clash_reg && $stable(tx_reg)))
      else $error("collision not flagged");
   a_buf_hold: assert property (@(posedge clock) disable iff (sys_rst)
      done_reg |=> (done_reg ? $stable(buf_reg) : 1'b1))
      else $error("buffer overwritten");
   a_master_start: assert property (@(posedge clock) disable iff (sys_rst)
      $rose(m_busy) |-> $past(clk_en && is_master && wr_ok))
      else $error("master started without write");
   a_no_slave_fault: assert property (@(posedge clock) disable iff (sys_rst)
      (clk_en && !is_master && !fault_reg) |=> !fault_reg)
      else $error("slave set fault");
endmodule : spisl_core

// File: bench/spisl_pm.sv
// External serial master model for the slave-side pins of the port.
// Assumes the bench calls its tasks one at a time; link clock period 125 ns.
module spisl_pm (
   output logic sck,
   output logic mosi,
   output logic sel_n,
   input wire logic miso_out,
   input wire logic miso_oe
);
   timeunit 1ns;
   timeprecision 100ps;
   localparam real HP = 62.5;
   initial begin
      sck = 1'b0;
      mosi = 1'b0;
      sel_n = 1'b1;
   end
   // Clock stands at the idle level outside frames
   task automatic xfer(input logic [7:0] tx, input logic pol, input logic pha,
         output logic [7:0] rx);
      int i;
      sck = pol;
      // Settle a new idle level before selecting, so no stray edge lands in the frame
      #(HP);
      sel_n = 1'b0;
      #(HP);
      for (i = 7; i >= 0; i--) begin
         if (!pha) mosi = tx[i];
         #(HP);
         // Sample just ahead of each capture edge, in the edge's own time step before it changes
         if (!pha) rx[i] = miso_oe ? miso_out : 1'bz;
         sck = ~pol;
         if (pha) mosi = tx[i];
         #(HP);
         if (pha) rx[i] = miso_oe ? miso_out : 1'bz;
         sck = pol;
      end
      #(HP) sel_n = 1'b1;
      // Released data line shows the inverse, not a held value
      mosi = ~mosi;
      #(8 * HP);
   endtask : xfer
   // Breaks the master's select-high rule on purpose
   task automatic pull_sel(input int ns);
      sel_n = 1'b0;
      #(ns);
      sel_n = 1'b1;
      #(ns);
   endtask : pull_sel
endmodule : spisl_pm

// File: bench/tb.sv
// Self-checking bench for the serial port core with an external master model.
// Assumes the core's CPU strobes are one-cycle pulses and flags are registers.
module tb;
   timeunit 1ns;
   timeprecision 100ps;
   import spisl_pkg::*;
   localparam int OP_CR = 0;
   localparam int OP_SRR = 1;
   localparam int OP_DW = 3;
   localparam int OP_DR = 4;
   typedef struct packed {
      logic [7:0] cr;
      logic mask;
      logic [7:0] stx;
      logic [7:0] mtx;
   } spisl_row_t;
   spisl_row_t rows [4] = '{'{8'h40, 1'b0, 8'hA1, 8'h5C}, '{8'hC7, 1'b0, 8'h3E, 8'hC9},
      '{8'h68, 1'b0, 8'h81, 8'h7E}, '{8'hCC, 1'b1, 8'h12, 8'hED}};
   logic clock, sys_rst, clk_en, ctrl_wr, status_rd, status_wr, data_wr, data_rd;
   logic cpu_irq_mask, sck_out, sck_oe, mosi_out, mosi_oe, miso_out, miso_oe, irq_req;
   logic link_sck, link_mosi_in, link_sel_n;
   logic [7:0] ctrl_wdata, data_wdata, ctrl_rdata, status_rdata, data_rdata, rx;
   wire logic link_miso_in;
   int fail_count = 0;
   int num_checks = 0;
   int sck_edges = 0;
   int edges;
   // Far slave echoes the master's data line
   assign link_miso_in = mosi_oe ? mosi_out : ~mosi_out;
   always @(posedge sck_out) sck_edges++;
   spisl_core dut_u (.clock(clock), .sys_rst(sys_rst), .clk_en(clk_en),
      .link_sck(link_sck), .link_mosi_in(link_mosi_in), .link_miso_in(link_miso_in),
      .link_sel_n(link_sel_n), .sck_out(sck_out), .sck_oe(sck_oe), .mosi_out(mosi_out),
      .mosi_oe(mosi_oe), .miso_out(miso_out), .miso_oe(miso_oe), .ctrl_wdata(ctrl_wdata),
      .ctrl_wr(ctrl_wr), .ctrl_rdata(ctrl_rdata), .status_rd(status_rd),
      .status_wr(status_wr), .status_rdata(status_rdata), .data_wdata(data_wdata),
      .data_wr(data_wr), .data_rd(data_rd), .data_rdata(data_rdata),
      .cpu_irq_mask(cpu_irq_mask), .irq_req(irq_req));
   spisl_pm pm_u (.sck(link_sck), .mosi(link_mosi_in), .sel_n(link_sel_n),
      .miso_out(miso_out), .miso_oe(miso_oe));
   initial begin
      clock = 1'b0;
      forever #20 clock = ~clock;
   end
   task automatic print_verdict();
      if (fail_count == 0 && num_checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : print_verdict
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      num_checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk
   task automatic cpu(input int op, input logic [7:0] d);
      @(posedge clock);
      ctrl_wdata <= d;
      data_wdata <= d;
      ctrl_wr <= (op == OP_CR);
      status_rd <= (op == OP_SRR);
      data_wr <= (op == OP_DW);
      data_rd <= (op == OP_DR);
      @(posedge clock);
      {ctrl_wr, status_rd, data_wr, data_rd} <= 4'h0;
      #1;
   endtask : cpu
   task automatic wait_done();
      int n;
      n = 0;
      while (status_rdata[SPISL_SR_DONE] !== 1'b1 && n < 300) begin
         @(posedge clock);
         n++;
      end
      if (n == 300) begin
         fail_count++;
         print_verdict();
      end else begin
         #1;
      end
   endtask : wait_done
   task automatic clr();
      cpu(OP_SRR, 8'h00);
      cpu(OP_DR, 8'h00);
   endtask : clr
   initial begin
      {ctrl_wr, status_rd, status_wr, data_wr, data_rd, cpu_irq_mask} = 6'h00;
      {ctrl_wdata, data_wdata} = 16'h0000;
      clk_en = 1'b1;
      sys_rst = 1'b1;
      repeat (20) @(posedge clock);
      sys_rst <= 1'b0;
      #1;
      chk(status_rdata, 8'h00);
      chk(ctrl_rdata, SPISL_CR_RST);
      chk({5'h00, sck_oe, mosi_oe, miso_oe}, 8'h00);
      // Warm-up byte settles the unreset link-side registers
      cpu(OP_CR, 8'h40);
      pm_u.xfer(8'h00, 1'b0, 1'b0, rx);
      wait_done();
      clr();
      foreach (rows[k]) begin
         @(posedge clock);
         cpu_irq_mask <= rows[k].mask;
         cpu(OP_CR, rows[k].cr);
         cpu(OP_DW, rows[k].stx);
         pm_u.xfer(rows[k].mtx, rows[k].cr[SPISL_CR_IDLE], rows[k].cr[SPISL_CR_PHASE], rx);
         wait_done();
         chk(rx, rows[k].stx);
         chk(data_rdata, rows[k].mtx);
         chk(irq_req, rows[k].cr[SPISL_CR_IRQEN] & ~rows[k].mask);
         clr();
         chk(status_rdata, 8'h00);
      end
      @(posedge clock);
      cpu_irq_mask <= 1'b0;
      // Overrun: buffer keeps the first byte, the write while done is dropped
      cpu(OP_CR, 8'h40);
      pm_u.xfer(8'hB1, 1'b0, 1'b0, rx);
      pm_u.xfer(8'hB2, 1'b0, 1'b0, rx);
      wait_done();
      chk(data_rdata, 8'hB1);
      cpu(OP_DW, 8'hA5);
      clr();
      pm_u.xfer(8'h00, 1'b0, 1'b0, rx);
      chk(rx, 8'hB2);
      wait_done();
      clr();
      // Slave collision with select low
      cpu(OP_CR, 8'hC0);
      cpu(OP_DW, 8'h5A);
      fork
         pm_u.xfer(8'h0F, 1'b0, 1'b0, rx);
         begin
            repeat (6) @(posedge clock);
            cpu(OP_DW, 8'hFF);
            chk(status_rdata[SPISL_SR_CLASH], 1'b1);
            chk(irq_req, 1'b0);
         end
      join
      wait_done();
      chk(rx, 8'h5A);
      chk(data_rdata, 8'h0F);
      clr();
      chk(status_rdata, 8'h00);
      // Master mode: idle level, start on write, collision
      cpu(OP_CR, 8'h58);
      chk(sck_out, 1'b1);
      cpu(OP_CR, 8'h50);
      chk(sck_out, 1'b0);
      edges = sck_edges;
      repeat (40) @(posedge clock);
      chk(8'(sck_edges - edges), 8'h00);
      cpu(OP_DW, 8'h96);
      cpu(OP_DW, 8'h11);
      chk(status_rdata[SPISL_SR_CLASH], 1'b1);
      wait_done();
      chk(8'(sck_edges - edges), 8'h08);
      chk(data_rdata, 8'h96);
      clr();
      // Master with phase set: echo must return the byte unchanged
      cpu(OP_CR, 8'h54);
      cpu(OP_DW, 8'h3C);
      wait_done();
      chk(data_rdata, 8'h3C);
      clr();
      // Mode fault and its clearing sequence
      cpu(OP_CR, 8'hD0);
      pm_u.pull_sel(400);
      chk(status_rdata, 8'h10);
      chk(ctrl_rdata & 8'h50, 8'h00);
      chk(irq_req, 1'b1);
      cpu(OP_CR, 8'hD0);
      chk(ctrl_rdata & 8'h50, 8'h00);
      chk(status_rdata, 8'h10);
      cpu(OP_SRR, 8'h00);
      cpu(OP_CR, 8'hD0);
      chk(status_rdata, 8'h00);
      chk(ctrl_rdata, 8'hD0);
      cpu(OP_CR, 8'h40);
      pm_u.xfer(8'h77, 1'b0, 1'b0, rx);
      wait_done();
      chk(status_rdata, 8'h80);
      print_verdict();
   end
endmodule : tb
